// ---- bench/ict_host.sv ----
/*
  Host model: writes control words and counts as one-cycle pulses.
  Assumes the bench calls its tasks between counter clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ict_host (
  input  wire logic       sys_clk,
  output logic            cfg_wr,
  output logic      [2:0] cfg_mode,
  output logic            cfg_bcd,
  output logic            cnt_wr_lo,
  output logic            cnt_wr_hi,
  output logic      [7:0] cnt_byte
);
  logic [2:0] cur_mode;

  initial begin
    cfg_wr    = 1'b0;
    cfg_mode  = 3'h0;
    cfg_bcd   = 1'b0;
    cnt_wr_lo = 1'b0;
    cnt_wr_hi = 1'b0;
    cnt_byte  = 8'h00;
    cur_mode  = 3'h0;
  end

  task automatic put_cfg(input logic [2:0] m, input logic b);
    @(negedge sys_clk);
    cfg_wr   = 1'b1;
    cfg_mode = m;
    cfg_bcd  = b;
    cur_mode = m;
    @(negedge sys_clk);
    cfg_wr   = 1'b0;
    // Released fields change so a stale value is never mistaken for a hold
    cfg_mode = ~m;
    cfg_bcd  = ~b;
  endtask

  // Count goes low byte first, then high byte, as the channel expects
  task automatic put_cnt(input logic [15:0] n);
    logic [15:0] v;
    v = n;
    if (cur_mode == 3'h2 && v == 16'h0001)
      v = 16'h0002;
    @(negedge sys_clk);
    cnt_wr_lo = 1'b1;
    cnt_byte  = v[7:0];
    @(negedge sys_clk);
    cnt_wr_lo = 1'b0;
    cnt_wr_hi = 1'b1;
    cnt_byte  = v[15:8];
    @(negedge sys_clk);
    cnt_wr_hi = 1'b0;
    cnt_byte  = ~v[15:8];
  endtask
endmodule
`default_nettype wire

// ---- bench/interval_counter_modes_1_to_5_tb.sv ----
/*
  Self-checking bench: reference model of modes one to five against the channel.
  Assumes counter clock and gate far slower than sys_clk; the bench makes both.
*/
`timescale 1ns/1ps
`default_nettype none
module interval_counter_modes_1_to_5_tb;
  logic        sys_clk;
  logic        reset_n;
  logic        ctr_clk;
  logic        gate;
  logic        cfg_wr;
  logic [2:0]  cfg_mode;
  logic        cfg_bcd;
  logic        cnt_wr_lo;
  logic        cnt_wr_hi;
  logic [7:0]  cnt_byte;
  logic        ctr_out;
  logic [15:0] count_value;
  logic [15:0] seed;
  logic [7:0]  lo;
  int          n_errors;
  int          samples_checked;
  int          md;
  int          hd;
  int          el;
  bit          o = 1'b1;
  bit          arm;
  bit          pend;
  bit          run;
  bit          ex;
  bit          tl;
  bit          tr;
  bit          gs;

  ict_counter ict_counter_inst (.sys_clk(sys_clk), .reset_n(reset_n), .ctr_clk(ctr_clk), .gate(gate),
    .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .cfg_bcd(cfg_bcd), .cnt_wr_lo(cnt_wr_lo), .cnt_wr_hi(cnt_wr_hi),
    .cnt_byte(cnt_byte), .ctr_out(ctr_out), .count_value(count_value));
  ict_host ict_host_inst (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .cfg_bcd(cfg_bcd),
    .cnt_wr_lo(cnt_wr_lo), .cnt_wr_hi(cnt_wr_hi), .cnt_byte(cnt_byte));

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int rel();
    return (md == 3 && hd % 2) ? hd - 1 : hd;
  endfunction

  always @(posedge sys_clk) begin
    if (cfg_wr) begin
      md   = cfg_mode;
      o    = 1;
      lo   = 8'h00;
      arm  = 0;
      pend = 0;
      run  = 0;
      ex   = 0;
    end else begin
      if (cnt_wr_hi) begin
        hd   = {cnt_byte, lo};
        arm  = 1;
        pend = 1;
      end
      if (cnt_wr_lo)
        lo = cnt_byte;
    end
  end

  always @(posedge ctr_clk) begin
    gs = gate;
    tr = tl;
    tl = 0;
  end

  always @(posedge gate)
    tl = 1;

  always @(negedge gate)
    if (md == 2 || md == 3)
      o = 1;

  always @(negedge ctr_clk) begin
    if (md == 1) begin
      if (tr && arm) begin
        el  = hd;
        o   = 0;
        run = 1;
      end else if (run) begin
        el  = el - 1;
        o   = (el == 0);
        run = !o;
      end
    end else if (md == 2 || md == 3) begin
      if ((tr && arm) || (pend && !run)) begin
        el   = rel();
        o    = 1;
        run  = 1;
        pend = 0;
        ex   = 0;
      end else if (ex) begin
        ex = 0;
        o  = 0;
        el = rel();
      end else if (run && gs && md == 2) begin
        el = o ? el - 1 : hd;
        o  = !o || el != 1;
      end else if (run && gs) begin
        ex = (el == 2 && hd % 2 && o);
        o  = (el == 2 && !ex) ? !o : o;
        el = (el != 2) ? el - 2 : ex ? 0 : rel();
      end
      if (!gate)
        o = 1;
    end else if (md == 4 || md == 5) begin
      if ((md == 4 && pend) || (md == 5 && tr && arm)) begin
        el   = hd;
        o    = 1;
        run  = 1;
        pend = 0;
      end else if (!o)
        o = 1;
      else if (run && (gs || md == 5)) begin
        el  = el - 1;
        o   = (el != 0);
        run = o;
      end
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One counter clock; gate moves just after the fall, well clear of the next rise
  task automatic cyc(input logic g);
    ctr_clk = 1'b1;
    repeat (10) @(negedge sys_clk);
    ctr_clk = 1'b0;
    repeat (2) @(negedge sys_clk);
    gate = g;
    repeat (7) @(negedge sys_clk);
    chk("ctr_out", {15'h0, ctr_out}, {15'h0, o});
    if (run)
      chk("count_value", count_value, el[15:0]);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    ctr_clk = 1'b0;
    gate    = 1'b0;
    seed    = 16'hf6e3;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk("ctr_out", {15'h0, ctr_out}, 16'h0001);
    chk("count_value", count_value, 16'h0000);
    for (int m = 1; m <= 5; m++) begin
      for (int r = 0; r < 2; r++) begin
        seed = nx(seed);
        ict_host_inst.put_cfg(m[2:0], seed[8]);
        @(negedge sys_clk);
        chk("ctr_out", {15'h0, ctr_out}, 16'h0001);
        // Counts stay below ten so decimal and binary runs share one model
        ict_host_inst.put_cnt(16'(2 + 2 * seed[1:0] + r));
        for (int k = 0; k < 40; k++) begin
          seed = nx(seed);
          if (k == 17)
            ict_host_inst.put_cnt(16'(2 + 2 * seed[4:3] + r));
          cyc(seed[2:0] != 3'h0);
        end
        if (m == 2 || m == 3) begin
          for (int k = 0; k < 20 && !(m == 2 ? o && el == 2 : !o && el != 2); k++)
            cyc(1'b1);
          cyc(1'b0);
          cyc(1'b1);
        end
      end
    end
    // Idle code: output stays high and the element stays clear whatever the gate does
    ict_host_inst.put_cfg(3'h6, seed[8]);
    ict_host_inst.put_cnt(16'h0003);
    cyc(1'b0);
    cyc(1'b1);
    chk("count_value", count_value, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- core/ict_counter.sv ----
/*
  One interval counter channel, modes one to five, with its gate logic.
  Assumes the host ports are pulses on sys_clk and that the counter clock
  and gate pins are asynchronous and much slower than sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - One-shot output starts high, drops after a trigger, rises when count hits zero.
// - Every one-shot trigger restarts the pulse; low for N counter clocks.
// - Once count is written the one-shot is armed; triggers repeat without rewrite.
// - A one-shot count written mid-pulse waits for the next trigger.
// - Rate mode drops output one clock at count one, then reloads; period N.
// - Rate mode: low gate halts counting; gate falling forces output high.
// - Rate mode trigger reloads on next clock; low follows N clocks later.
// - Rate mode loads on the clock after the first count write.
// - Rate mode new count waits for period end unless a trigger comes.
// - Square mode period N, high first half, low the rest.
// - Square mode: low gate halts; gate falling with output low forces high.
// - Square mode new count waits for half-cycle end unless triggered.
// - Even square count: step by two, toggle and reload at expiry.
// - Odd square count: load N-1, step by two, delay falling edge one clock.
// - Software strobe loads without decrement; low pulse N+1 clocks after write.
// - First byte of two leaves counting alone; second byte loads next clock.
// - Software strobe rewrite restarts; strobe N+1 clocks after new write.
// - Hardware strobe loads only after a trigger; strobe N+1 clocks later.
// - Hardware strobe new count used at the next trigger, before or after expiry.
// - One-shot starts on gate rise; software strobe counts only while gate high.
// - Loads and decrements happen on the counter clock falling edge.
// - Gate sampled on counter clock rise; trigger latch cleared after sampling.
// - A count of zero means 65536 binary or 10000 decimal.
module ict_counter
  import ict_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        ctr_clk,
  input  wire logic        gate,
  input  wire logic        cfg_wr,
  input  wire logic [2:0]  cfg_mode,
  input  wire logic        cfg_bcd,
  input  wire logic        cnt_wr_lo,
  input  wire logic        cnt_wr_hi,
  input  wire logic [7:0]  cnt_byte,
  output logic             ctr_out,
  output logic      [15:0] count_value
);

  ict_state_s  st_r;
  ict_state_s  st_nxt;
  logic [1:0]  pins_s;
  logic        clk_s;
  logic        gate_s;
  logic        ctr_rise;
  logic        ctr_fall;
  logic        trig_go;
  logic [15:0] elem_m1;
  logic [15:0] elem_m2;
  logic [15:0] hold_m1;
  logic [15:0] sq_reload;

  ict_sync u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     ({gate, ctr_clk}),
    .dout    (pins_s)
  );

  // Decrementers wrap zero to the top value, so zero acts as the largest count
  ict_dec u_dec_e1 (
    .val (st_r.elem),
    .bcd (st_r.bcd),
    .res (elem_m1)
  );

  ict_dec u_dec_e2 (
    .val (elem_m1),
    .bcd (st_r.bcd),
    .res (elem_m2)
  );

  ict_dec u_dec_h1 (
    .val (st_r.hold),
    .bcd (st_r.bcd),
    .res (hold_m1)
  );

  assign clk_s     = pins_s[LANE_CLK];
  assign gate_s    = pins_s[LANE_GATE];
  assign ctr_rise  = clk_s && !st_r.clk_prev;
  assign ctr_fall  = !clk_s && st_r.clk_prev;
  assign trig_go   = st_r.trig_smp && st_r.armed;
  // Odd counts run on N-1 so the two half-cycles stay even steps
  assign sq_reload = st_r.hold[0] ? hold_m1 : st_r.hold;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.clk_prev  = clk_s;
    st_nxt.gate_prev = gate_s;

    if (ctr_rise) begin
      st_nxt.trig_smp = st_r.trig_ff;
      st_nxt.gate_smp = gate_s;
      st_nxt.trig_ff  = 1'b0;
    end
    // A gate edge in the sampling cycle is kept: set beats clear
    if (gate_s && !st_r.gate_prev) begin
      st_nxt.trig_ff = 1'b1;
    end

    // All loads and decrements act on the counter clock falling edge
    if (ctr_fall) begin
      unique case (st_r.mode)
        MODE_ONESHOT: begin
          if (trig_go) begin
            st_nxt.elem = st_r.hold;
            st_nxt.out  = 1'b0;
            st_nxt.run  = 1'b1;
          end else begin
            st_nxt.elem = elem_m1;
            if (st_r.run && st_r.elem == COUNT_ONE) begin
              st_nxt.out = 1'b1;
              st_nxt.run = 1'b0;
            end
          end
        end
        MODE_RATE: begin
          if (st_r.load_pend || trig_go) begin
            st_nxt.elem      = st_r.hold;
            st_nxt.load_pend = 1'b0;
            st_nxt.out       = 1'b1;
          end else if (!st_r.out) begin
            st_nxt.out  = 1'b1;
            st_nxt.elem = st_r.hold;
          end else if (st_r.gate_smp && st_r.armed) begin
            st_nxt.elem = elem_m1;
            if (st_r.elem == COUNT_TWO) begin
              st_nxt.out = 1'b0;
            end
          end
        end
        MODE_SQUARE: begin
          if (st_r.load_pend || trig_go) begin
            st_nxt.elem      = sq_reload;
            st_nxt.load_pend = 1'b0;
            st_nxt.extra     = 1'b0;
            st_nxt.out       = 1'b1;
          end else if (st_r.extra) begin
            st_nxt.extra = 1'b0;
            st_nxt.out   = 1'b0;
            st_nxt.elem  = sq_reload;
          end else if (st_r.gate_smp && st_r.armed) begin
            if (st_r.elem == COUNT_TWO) begin
              if (st_r.hold[0] && st_r.out) begin
                st_nxt.extra = 1'b1;
                st_nxt.elem  = COUNT_EXP;
              end else begin
                st_nxt.out  = !st_r.out;
                st_nxt.elem = sq_reload;
              end
            end else begin
              st_nxt.elem = elem_m2;
            end
          end
        end
        MODE_SWSTB: begin
          if (st_r.load_pend) begin
            st_nxt.elem      = st_r.hold;
            st_nxt.load_pend = 1'b0;
            st_nxt.run       = 1'b1;
            st_nxt.out       = 1'b1;
          end else begin
            st_nxt.out = 1'b1;
            if (st_r.gate_smp) begin
              st_nxt.elem = elem_m1;
              if (st_r.run && st_r.elem == COUNT_ONE) begin
                st_nxt.out = 1'b0;
                st_nxt.run = 1'b0;
              end
            end
          end
        end
        MODE_HWSTB: begin
          if (trig_go) begin
            st_nxt.elem = st_r.hold;
            st_nxt.run  = 1'b1;
            st_nxt.out  = 1'b1;
          end else begin
            st_nxt.out  = 1'b1;
            st_nxt.elem = elem_m1;
            if (st_r.run && st_r.elem == COUNT_ONE) begin
              st_nxt.out = 1'b0;
              st_nxt.run = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Count writes come after the loads so a write landing on a fall stays pending
    if (cnt_wr_lo) begin
      st_nxt.lo_byte = cnt_byte;
    end
    if (cnt_wr_hi) begin
      st_nxt.hold  = {cnt_byte, st_r.lo_byte};
      st_nxt.armed = 1'b1;
      if (st_r.mode == MODE_SWSTB) begin
        st_nxt.load_pend = 1'b1;
      end else if (!st_r.armed && (st_r.mode == MODE_RATE || st_r.mode == MODE_SQUARE)) begin
        st_nxt.load_pend = 1'b1;
      end
    end

    // One sys_clk after the synchronised gate drops, not truly without a clock
    if ((st_r.mode == MODE_RATE || st_r.mode == MODE_SQUARE) && !gate_s) begin
      st_nxt.out = 1'b1;
    end

    // A control word resets the sequencer; it wins over a same-cycle count write
    if (cfg_wr) begin
      st_nxt.mode      = cfg_mode;
      st_nxt.bcd       = cfg_bcd;
      st_nxt.out       = 1'b1;
      st_nxt.armed     = 1'b0;
      st_nxt.load_pend = 1'b0;
      st_nxt.run       = 1'b0;
      st_nxt.extra     = 1'b0;
      st_nxt.trig_smp  = 1'b0;
      st_nxt.elem      = COUNT_RESET;
      st_nxt.lo_byte   = BYTE_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r           <= '0;
      st_r.mode      <= MODE_RESET;
      st_r.hold      <= COUNT_RESET;
      st_r.elem      <= COUNT_RESET;
      st_r.out       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctr_out     = st_r.out;
  assign count_value = st_r.elem;

  cw_reset_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cfg_wr |=> (ctr_out && !st_r.armed && count_value == COUNT_RESET))
    else $error("control word did not reset the channel");

  one_shot_drop_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_ONESHOT && ctr_fall && trig_go && !cfg_wr)
      |=> (!ctr_out && count_value == $past(st_r.hold)))
    else $error("one-shot trigger did not start the pulse");

  rate_pulse_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_RATE && ctr_fall && !st_r.load_pend && !trig_go && st_r.out
      && st_r.gate_smp && st_r.armed && st_r.elem == COUNT_TWO && !cfg_wr && gate_s)
      |=> (!ctr_out || !gate_s))
    else $error("rate output did not drop at count one");

  gate_force_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ((st_r.mode == MODE_RATE || st_r.mode == MODE_SQUARE) && !gate_s) |=> ctr_out)
    else $error("low gate did not force the output high");

  rate_first_load_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_RATE && cnt_wr_hi && !st_r.armed && !cfg_wr) |=> st_r.load_pend)
    else $error("first rate count not queued for loading");

  sq_even_elem_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_SQUARE) |-> !count_value[0])
    else $error("square count element went odd");

  strobe_one_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ((st_r.mode == MODE_SWSTB || st_r.mode == MODE_HWSTB) && ctr_fall && !ctr_out)
      |=> ctr_out)
    else $error("strobe lasted longer than one counter clock");

  sw_load_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_SWSTB && ctr_fall && st_r.load_pend && !cfg_wr)
      |=> (count_value == $past(st_r.hold) && ctr_out))
    else $error("software strobe count not loaded");

  hw_wait_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_HWSTB && ctr_fall && !trig_go && !cfg_wr)
      |=> (count_value == $past(elem_m1)))
    else $error("hardware strobe loaded without a trigger");

  zero_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_ONESHOT && ctr_fall && !trig_go && !cfg_wr && st_r.elem == COUNT_RESET)
      |=> (count_value == (st_r.bcd ? BCD_WRAP : BIN_WRAP)))
    else $error("zero count did not wrap to the top");

  one_shot_c: cover property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_ONESHOT && !ctr_out) ##1 ctr_out);

  rate_low_c: cover property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_RATE && !ctr_out));

  square_low_c: cover property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_SQUARE && st_r.extra) ##1 !ctr_out);

  hw_strobe_c: cover property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_r.mode == MODE_HWSTB && !ctr_out));

endmodule
`default_nettype wire

// ---- core/ict_dec.sv ----
/*
  Decrement-by-one of a sixteen-bit count, binary or four-digit decimal.
  Assumes decimal inputs hold valid digits; zero wraps to the top value.
*/
`timescale 1ns/1ps
`default_nettype none
module ict_dec
  import ict_pkg::*;
(
  input  wire logic [15:0] val,
  input  wire logic        bcd,
  output logic      [15:0] res
);

  logic [3:0]  brw;
  logic [15:0] bcd_res;

  assign brw[0] = 1'b1;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_dig
      logic [3:0] dig;
      assign dig = val[4*i +: 4];
      assign bcd_res[4*i +: 4] = !brw[i] ? dig : ((dig == 4'h0) ? 4'h9 : dig - 4'h1);
      if (i < 3) begin : g_brw
        assign brw[i+1] = brw[i] && (dig == 4'h0);
      end
    end
  endgenerate

  assign res = bcd ? bcd_res : val - COUNT_ONE;

endmodule
`default_nettype wire

// ---- core/ict_sync.sv ----
/*
  Two-stage synchroniser for the counter clock and gate pins.
  Assumes both inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ict_sync
  import ict_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ict_sync_s;

  ict_sync_s st_r;
  ict_sync_s st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;

endmodule
`default_nettype wire

// ---- include/ict_pkg.sv ----
/*
  Shared constants and the state record of the interval counter channel.
  Assumes that every file using it imports the whole package.
*/
package ict_pkg;

  // Mode field codes (only modes one to five count; the rest sit idle)
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE    = 3'h2;
  localparam logic [2:0] MODE_SQUARE  = 3'h3;
  localparam logic [2:0] MODE_SWSTB   = 3'h4;
  localparam logic [2:0] MODE_HWSTB   = 3'h5;

  // Reset values
  localparam logic [2:0]  MODE_RESET  = 3'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // Count values the sequencer compares against or loads, and the wrap tops the checks expect
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [15:0] COUNT_TWO   = 16'h0002;
  localparam logic [15:0] COUNT_EXP   = 16'h0000;
  localparam logic [15:0] BIN_WRAP    = 16'hffff;
  localparam logic [15:0] BCD_WRAP    = 16'h9999;

  // Synchroniser lane positions
  localparam int LANE_CLK  = 0;
  localparam int LANE_GATE = 1;

  typedef struct packed {
    logic [15:0] hold;       // Written initial count
    logic [15:0] elem;       // Counting element
    logic [7:0]  lo_byte;    // First byte of a two-byte count
    logic [2:0]  mode;
    logic        bcd;
    logic        out;
    logic        armed;
    logic        load_pend;
    logic        run;
    logic        extra;      // Odd square count: one more clock before going low
    logic        trig_ff;
    logic        trig_smp;
    logic        gate_smp;
    logic        clk_prev;
    logic        gate_prev;
  } ict_state_s;

endpackage
